// ---- cca_pkg.sv ----
package cca_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [5:0] ADDR_STATUS = 6'h01;
    localparam logic [5:0] ADDR_CONTROL = 6'h08;
    localparam logic [5:0] ADDR_THRESHOLD = 6'h09;

    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h2b;
    localparam logic [7:0] THRESHOLD_RESET = 8'hc7;

    localparam int STATUS_DONE_BIT = 7;
    localparam int STATUS_IDLE_BIT = 6;
    localparam int CONTROL_REQ_BIT = 7;
    localparam int METHOD_LSB = 5;
    localparam int CHANNEL_MSB = 4;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int RESULT_TIME_US = 140;
    localparam int RESULT_CYCLES = (RESULT_TIME_US * 1000000) / CLK_PERIOD_PS;
    localparam int MEASURE_TIME_US = 128;
    localparam int MEASURE_CYCLES = (MEASURE_TIME_US * 1000000) / CLK_PERIOD_PS;

    // ------------------------------------------------------------------
    // Assessment methods
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        METHOD_CS_OR_ED = 2'h0,
        METHOD_ED = 2'h1,
        METHOD_CS = 2'h2,
        METHOD_CS_AND_ED = 2'h3
    } cca_method_type;

    // Channel observations from the receiver.
    typedef struct packed {
        logic carrier_seen;
        logic [7:0] energy_level;
    } cca_obs_type;

    // Register write strobe with address and data.
    typedef struct packed {
        logic write;
        logic [5:0] addr;
        logic [7:0] data;
    } cca_wr_type;

endpackage

// ---- cca_decide.sv ----
`timescale 1ns/100ps
`default_nettype none

// Combines the energy and carrier verdicts for the selected method.
module cca_decide (
    // Inputs
    input wire logic [1:0] method,
    input wire logic [4:0] threshold_step,
    input wire logic energy_valid,
    input wire cca_pkg::cca_obs_type obs,
    // Result
    output logic busy
);

    logic energy_busy;
    logic [7:0] limit;

    always_comb begin
        // Energy level counts 1 dB steps above the power floor.
        limit = {2'h0, threshold_step, 1'b0};
        energy_busy = energy_valid && (obs.energy_level > limit);
        case (cca_pkg::cca_method_type'(method))
            cca_pkg::METHOD_CS_OR_ED: busy = obs.carrier_seen || energy_busy;
            cca_pkg::METHOD_ED: busy = energy_busy;
            cca_pkg::METHOD_CS: busy = obs.carrier_seen;
            cca_pkg::METHOD_CS_AND_ED: busy = obs.carrier_seen && energy_busy;
            default: busy = 1'b0;
        endcase
    end

endmodule

`default_nettype wire

// ---- cca_core.sv ----
// Summary of operation
// - Idle listening: peak energy over the whole 140 us count, result ready 140 us after request.
// - A done pulse is raised when a manual assessment finishes.
// - Energy method: busy when power exceeds floor plus twice threshold step.
// - Each new request clears the idle flag, and the completion flag unless made outside basic receive states.
// - At the end, completion flag sets; idle flag shows no signal found.
// - Carrier method: busy when a compliant modulated signal is seen.
// - Request outside basic receive states: done pulse and flag, no measurement.
// - Request during energy measurement may pulse done early, then again later.
// - Busy receive, methods 1,3,0: wait for a running automated energy measurement to end, else result at once.
// - Busy receive, method 2: result available at once.
// - Sync header starts one 8-symbol energy measurement per frame.
// - Status register: done bit 7, idle bit 6, reserved 5, state 4..0.
// - Control register: write-only request bit 7, method, channel; resets 0x2b.
// - Method 0 OR, 1 energy, 2 carrier, 3 AND.
// - The request bit clears itself after a request.
// - Threshold register holds the five-bit step in bits 4..0.
`timescale 1ns/100ps
`default_nettype none

module cca_core #(
    parameter int RESULT_CYCLES = cca_pkg::RESULT_CYCLES,
    parameter int MEASURE_CYCLES = cca_pkg::MEASURE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register access
    input wire cca_pkg::cca_wr_type wr,
    input wire logic [5:0] rd_addr,
    output logic [7:0] rd_data,
    // Transceiver state
    input wire logic [4:0] transceiver_state,
    input wire logic listen_state,
    input wire logic busy_rx_state,
    input wire logic extended_mode,
    input wire logic sync_header_seen,
    input wire logic frame_end,
    input wire cca_pkg::cca_obs_type obs,
    // Outputs
    output logic measure_done_event,
    output logic [4:0] channel
);

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LISTEN = 4'b0010,
        ST_WAIT_ED = 4'b0100,
        ST_FINISH = 4'b1000
    } cca_state_type;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    cca_state_type state_reg, state_next;
    logic [17:0] count_reg, count_next;
    logic [17:0] ed_count_reg, ed_count_next;
    logic ed_run_reg, ed_run_next;
    logic ed_valid_reg, ed_valid_next;
    logic ed_used_reg, ed_used_next;
    logic [7:0] ed_level_reg, ed_level_next;
    logic [7:0] ed_acc_reg, ed_acc_next;
    logic seen_carrier_reg, seen_carrier_next;
    logic acc_listen_reg, acc_listen_next;
    logic done_reg, done_next;
    logic idle_reg, idle_next;
    logic [1:0] method_reg, method_next;
    logic [4:0] channel_reg, channel_next;
    logic [4:0] thresh_reg, thresh_next;
    logic [2:0] thresh_rsv_reg, thresh_rsv_next;
    logic irq_reg, irq_next;
    logic [7:0] rd_reg, rd_next;

    logic busy;
    logic request;
    cca_pkg::cca_obs_type eval_obs;

    assign request = wr.write && (wr.addr == cca_pkg::ADDR_CONTROL)
        && wr.data[cca_pkg::CONTROL_REQ_BIT];

    cca_decide u_decide (
        .method(method_reg),
        .threshold_step(thresh_reg),
        .energy_valid(1'b1),
        .obs(eval_obs),
        .busy(busy)
    );

    function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
        max8 = (a > b) ? a : b;
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        ed_count_next = ed_count_reg;
        ed_run_next = ed_run_reg;
        ed_valid_next = ed_valid_reg;
        ed_used_next = ed_used_reg;
        ed_level_next = ed_level_reg;
        ed_acc_next = ed_acc_reg;
        seen_carrier_next = seen_carrier_reg;
        acc_listen_next = acc_listen_reg;
        done_next = done_reg;
        idle_next = idle_reg;
        method_next = method_reg;
        channel_next = channel_reg;
        thresh_next = thresh_reg;
        thresh_rsv_next = thresh_rsv_reg;
        irq_next = 1'b0;
        eval_obs.carrier_seen = obs.carrier_seen;
        eval_obs.energy_level = ed_level_reg;

        // Automated energy measurement, once per frame.
        if (frame_end) begin
            ed_used_next = 1'b0;
            ed_valid_next = 1'b0;
        end
        if (sync_header_seen && !ed_used_reg && !ed_run_reg) begin
            ed_run_next = 1'b1;
            ed_used_next = 1'b1;
            ed_valid_next = 1'b0;
            ed_count_next = 18'(MEASURE_CYCLES);
            ed_acc_next = obs.energy_level;
        end else if (ed_run_reg) begin
            // Peak energy stands in for the average; cheaper, more cautious.
            ed_acc_next = max8(ed_acc_reg, obs.energy_level);
            ed_count_next = ed_count_reg - 18'h1;
            if (ed_count_reg == 18'h1) begin
                ed_run_next = 1'b0;
                ed_valid_next = 1'b1;
                ed_level_next = ed_acc_next;
            end
        end

        case (state_reg)
            ST_IDLE: begin
            end
            ST_LISTEN: begin
                seen_carrier_next = seen_carrier_reg || obs.carrier_seen;
                ed_acc_next = max8(ed_acc_reg, obs.energy_level);
                count_next = count_reg - 18'h1;
                if (count_reg == 18'h1) begin
                    state_next = ST_FINISH;
                end
            end
            ST_WAIT_ED: begin
                if (ed_valid_reg) begin
                    state_next = ST_FINISH;
                end
            end
            ST_FINISH: begin
                eval_obs.carrier_seen = seen_carrier_reg || obs.carrier_seen;
                // Listening keeps its own peak; receive results use the automated level.
                eval_obs.energy_level = acc_listen_reg ? ed_acc_reg : ed_level_reg;
                done_next = 1'b1;
                idle_next = !busy;
                irq_next = 1'b1;
                state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase

        if (wr.write && wr.addr == cca_pkg::ADDR_CONTROL) begin
            method_next = wr.data[cca_pkg::CONTROL_REQ_BIT-1:cca_pkg::METHOD_LSB];
            channel_next = wr.data[cca_pkg::CHANNEL_MSB:0];
        end
        if (wr.write && wr.addr == cca_pkg::ADDR_THRESHOLD) begin
            thresh_next = wr.data[4:0];
            thresh_rsv_next = wr.data[7:5];
        end

        if (request) begin
            done_next = 1'b0;
            idle_next = 1'b0;
            seen_carrier_next = obs.carrier_seen;
            acc_listen_next = 1'b0;
            if (extended_mode || !(listen_state || busy_rx_state)) begin
                done_next = 1'b1;
                irq_next = 1'b1;
                state_next = ST_IDLE;
            end else if (listen_state) begin
                state_next = ST_LISTEN;
                count_next = 18'(RESULT_CYCLES);
                acc_listen_next = 1'b1;
                ed_acc_next = obs.energy_level;
            end else if (wr.data[6:5] == 2'(cca_pkg::METHOD_CS)) begin
                state_next = ST_FINISH;
            end else if (ed_run_reg || ed_run_next) begin
                irq_next = 1'b1;
                state_next = ST_WAIT_ED;
            end else begin
                state_next = ST_FINISH;
            end
        end

        // Request bit is never stored, so it always reads back as zero.
        case (rd_addr)
            cca_pkg::ADDR_STATUS: rd_next = {done_reg, idle_reg, 1'b0, transceiver_state};
            cca_pkg::ADDR_CONTROL: rd_next = {1'b0, method_reg, channel_reg};
            cca_pkg::ADDR_THRESHOLD: rd_next = {thresh_rsv_reg, thresh_reg};
            default: rd_next = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            count_reg <= 18'h0;
            ed_count_reg <= 18'h0;
            ed_run_reg <= 1'b0;
            ed_valid_reg <= 1'b0;
            ed_used_reg <= 1'b0;
            ed_level_reg <= 8'h00;
            ed_acc_reg <= 8'h00;
            seen_carrier_reg <= 1'b0;
            acc_listen_reg <= 1'b0;
            done_reg <= cca_pkg::STATUS_RESET[cca_pkg::STATUS_DONE_BIT];
            idle_reg <= cca_pkg::STATUS_RESET[cca_pkg::STATUS_IDLE_BIT];
            method_reg <= cca_pkg::CONTROL_RESET[6:5];
            channel_reg <= cca_pkg::CONTROL_RESET[4:0];
            thresh_reg <= cca_pkg::THRESHOLD_RESET[4:0];
            thresh_rsv_reg <= cca_pkg::THRESHOLD_RESET[7:5];
            irq_reg <= 1'b0;
            rd_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            ed_count_reg <= ed_count_next;
            ed_run_reg <= ed_run_next;
            ed_valid_reg <= ed_valid_next;
            ed_used_reg <= ed_used_next;
            ed_level_reg <= ed_level_next;
            ed_acc_reg <= ed_acc_next;
            seen_carrier_reg <= seen_carrier_next;
            acc_listen_reg <= acc_listen_next;
            done_reg <= done_next;
            idle_reg <= idle_next;
            method_reg <= method_next;
            channel_reg <= channel_next;
            thresh_reg <= thresh_next;
            thresh_rsv_reg <= thresh_rsv_next;
            irq_reg <= irq_next;
            rd_reg <= rd_next;
        end
    end

    assign rd_data = rd_reg;
    assign measure_done_event = irq_reg;
    assign channel = channel_reg;

endmodule

`default_nettype wire

// ---- cca_core_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none

module cca_core_assertions #(
    parameter int RESULT_CYCLES = 20,
    parameter int MEASURE_CYCLES = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register access
    input wire cca_pkg::cca_wr_type wr,
    input wire logic [5:0] rd_addr,
    input wire logic [7:0] rd_data,
    // Transceiver state
    input wire logic [4:0] transceiver_state,
    input wire logic listen_state,
    input wire logic busy_rx_state,
    input wire logic extended_mode,
    // Outputs
    input wire logic measure_done_event,
    input wire logic [4:0] channel
);
    localparam int LAT = RESULT_CYCLES + 2;
    logic req;
    logic lreq;
    logic oreq;
    int wait_reg;
    assign req = wr.write && wr.addr == cca_pkg::ADDR_CONTROL && wr.data[7];
    assign lreq = req && listen_state && !busy_rx_state && !extended_mode;
    assign oreq = req && (extended_mode || !(listen_state || busy_rx_state));

    // A listening request restarts the count and any other request clears it, since a new request replaces the running assessment.
    always_ff @(posedge clk) begin
        if (sys_rst || (req && !lreq)) begin
            wait_reg <= 0;
        end else if (lreq) begin
            wait_reg <= 1;
        end else if (wait_reg >= LAT) begin
            wait_reg <= 0;
        end else if (wait_reg != 0) begin
            wait_reg <= wait_reg + 1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    listen_done_a: assert property (wait_reg == LAT |-> measure_done_event)
        else $error("No done pulse at the listening result time.");
    listen_wait_a: assert property (wait_reg != 0 && wait_reg < LAT |-> !measure_done_event)
        else $error("Done pulse before the listening result time.");
    outside_done_a: assert property (oreq |=> measure_done_event)
        else $error("No done pulse for a request outside receive states.");
    channel_field_a: assert property (
        wr.write && wr.addr == cca_pkg::ADDR_CONTROL |=> channel == $past(wr.data[4:0]))
        else $error("Channel output does not follow the control write.");
    status_state_a: assert property (
        rd_addr == cca_pkg::ADDR_STATUS && $stable(transceiver_state)
        |=> rd_data[5:0] == {1'b0, $past(transceiver_state)})
        else $error("Status low bits do not show the state code.");
    request_bit_a: assert property (rd_addr == cca_pkg::ADDR_CONTROL |=> !rd_data[7])
        else $error("Request bit reads as one.");
    flags_clear_a: assert property (
        lreq ##1 rd_addr == cca_pkg::ADDR_STATUS |=> rd_data[7:6] == 2'b00)
        else $error("Status flags not cleared by a request.");
    done_flag_a: assert property (
        measure_done_event && !busy_rx_state && !req && rd_addr == cca_pkg::ADDR_STATUS
        |=> rd_data[7])
        else $error("Completion flag low at the done pulse.");

    cover property (lreq ##LAT measure_done_event);
    cover property (oreq ##1 measure_done_event);
    cover property (req && busy_rx_state ##1 measure_done_event);
endmodule

`default_nettype wire

// ---- cca_host.sv ----
`timescale 1ns/100ps
`default_nettype none

module cca_host (
    // Clock
    input wire logic clk,
    // Register access
    output var cca_pkg::cca_wr_type wr,
    output var logic [5:0] rd_addr,
    input wire logic [7:0] rd_data
);
    initial begin
        wr = '0;
        rd_addr = cca_pkg::ADDR_STATUS;
    end

    // The strobe drops for a cycle between writes, so no write is taken twice.
    task automatic wr_reg(input logic [5:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= '{write: 1'b1, addr: a, data: v};
        @(posedge clk);
        wr <= '0;
    endtask

    // The address stays put afterwards, so status polling needs no extra cycle.
    task automatic rd_reg(input logic [5:0] a, output logic [7:0] v);
        @(posedge clk);
        rd_addr <= a;
        @(posedge clk);
        #1;
        v = rd_data;
    endtask
endmodule

`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb;
    localparam logic [5:0] ST = cca_pkg::ADDR_STATUS;
    localparam logic [5:0] CT = cca_pkg::ADDR_CONTROL;
    localparam logic [5:0] TH = cca_pkg::ADDR_THRESHOLD;
    localparam logic [4:0] S = 5'h06;
    logic clk;
    logic sys_rst = 1'b1;
    cca_pkg::cca_wr_type wr;
    logic [5:0] rd_addr;
    logic [7:0] rd_data;
    logic [4:0] tstate = S;
    logic lis = 1'b1;
    logic brx = 1'b0;
    logic ext = 1'b0;
    logic shs = 1'b0;
    logic fe = 1'b0;
    cca_pkg::cca_obs_type obs = '0;
    logic irq;
    logic [4:0] channel;
    logic [7:0] d;
    logic [7:0] ex;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;

    cca_core #(.RESULT_CYCLES(20), .MEASURE_CYCLES(16)) cca_core_i (
        .clk(clk), .sys_rst(sys_rst), .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data),
        .transceiver_state(tstate), .listen_state(lis), .busy_rx_state(brx),
        .extended_mode(ext), .sync_header_seen(shs), .frame_end(fe), .obs(obs),
        .measure_done_event(irq), .channel(channel));
    cca_host cca_host_i (.clk(clk), .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] exp, input string what);
        cca_host_i.rd_reg(a, d);
        chk(what, exp, d);
    endtask

    // The pulse stands for one cycle only, so every cycle is looked at.
    // The current cycle is looked at first: an immediate pulse rises at the write edge.
    task automatic pulse(input int lim, input logic exp);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < lim && !hit; i++) begin
            #1;
            hit = (irq === 1'b1);
            @(posedge clk);
        end
        chk("done pulse", {7'h0, exp}, {7'h0, hit});
    endtask

    function automatic logic idle(input logic [1:0] m, input logic cs, input logic eb);
        case (m)
            2'h0: return !(cs || eb);
            2'h1: return !eb;
            2'h2: return !cs;
            default: return !(cs && eb);
        endcase
    endfunction

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            $display("Error cycle limit expected below 5000 seen 5000");
            end_of_test();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        rd(ST, {3'h0, S}, "status reset");
        rd(CT, 8'h2b, "control reset");
        rd(TH, 8'hc7, "threshold reset");
        rd(6'h3f, 8'h00, "unmapped read");
        chk("channel reset", 8'h0b, {3'h0, channel});
        cca_host_i.wr_reg(CT, 8'h4c);
        pulse(30, 1'b0);
        rd(CT, 8'h4c, "control readback");
        chk("channel", 8'h0c, {3'h0, channel});
        cca_host_i.wr_reg(TH, 8'he5);
        rd(TH, 8'he5, "threshold readback");
        $display("Test registers done");
        // Energy 10 sits on the threshold 2 * 5 and is not busy; 11 is.
        for (int k = 0; k < 16; k++) begin
            obs <= '{carrier_seen: k[0], energy_level: 8'd10 + 8'(k[1])};
            cca_host_i.wr_reg(CT, {1'b1, 2'(k >> 2), 5'h0b});
            rd(ST, {3'h0, S}, "status cleared");
            pulse(40, 1'b1);
            ex = {1'b1, idle(2'(k >> 2), k[0], obs.energy_level > 8'd2 * 8'd5), 1'b0, S};
            rd(ST, ex, "listen result");
        end
        cca_host_i.wr_reg(CT, 8'hab);
        repeat (5) @(posedge clk);
        cca_host_i.wr_reg(CT, 8'hab);
        rd(ST, {3'h0, S}, "restart cleared");
        pulse(40, 1'b1);
        rd(ST, {3'h4, S}, "restart result");
        $display("Test listening done");
        for (int j = 0; j < 2; j++) begin
            lis <= 1'(j);
            ext <= 1'(j);
            cca_host_i.wr_reg(CT, 8'hab);
            pulse(3, 1'b1);
            rd(ST, {3'h4, S}, "outside done");
        end
        $display("Test outside receive done");
        lis <= 1'b0;
        ext <= 1'b0;
        brx <= 1'b1;
        obs <= '0;
        for (int r = 0; r < 2; r++) begin
            shs <= 1'b1;
            @(posedge clk);
            shs <= 1'b0;
            cca_host_i.wr_reg(CT, 8'hcb);
            pulse(3, 1'b1);
            rd(ST, {3'h6, S}, "carrier only");
            cca_host_i.wr_reg(CT, 8'hab);
            pulse(3, 1'b1);
            rd(ST, {3'h0, S}, "held result");
            pulse(30, 1'b1);
            rd(ST, {3'h6, S}, "energy result");
            shs <= 1'b1;
            @(posedge clk);
            shs <= 1'b0;
            cca_host_i.wr_reg(CT, 8'hab);
            pulse(3, 1'b1);
            rd(ST, {3'h6, S}, "after measurement");
            fe <= 1'b1;
            @(posedge clk);
            fe <= 1'b0;
        end
        $display("Test busy receive done");
        end_of_test();
    end
endmodule

bind cca_core cca_core_assertions #(
    .RESULT_CYCLES(RESULT_CYCLES), .MEASURE_CYCLES(MEASURE_CYCLES)
) cca_core_assertions_i (
    .clk(clk), .sys_rst(sys_rst), .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data),
    .transceiver_state(transceiver_state), .listen_state(listen_state),
    .busy_rx_state(busy_rx_state), .extended_mode(extended_mode),
    .measure_done_event(measure_done_event), .channel(channel));

`default_nettype wire
